/* include/cca_pkg.sv */
// Purpose: Shared constants for the counter array block
// Assumes: Byte-wide register port, five capture/compare modules
// Notes:   Register addresses are local to this block's register port
package cca_pkg;

	// --------------------------------------------------------------
	// Sizes
	// --------------------------------------------------------------
	localparam int CCA_MODS    = 5;
	localparam int CCA_AW      = 6;
	localparam int CCA_WDT_MOD = 4;

	// --------------------------------------------------------------
	// Register addresses
	// --------------------------------------------------------------
	localparam logic [5:0] CCA_A_CNT_LO = 6'h00;
	localparam logic [5:0] CCA_A_CNT_HI = 6'h01;
	localparam logic [5:0] CCA_A_MODE   = 6'h02;
	localparam logic [5:0] CCA_A_CTRL   = 6'h03;
	localparam logic [5:0] CCA_A_MMODE0 = 6'h10;
	localparam logic [5:0] CCA_A_VLO0   = 6'h18;
	localparam logic [5:0] CCA_A_VHI0   = 6'h20;

	// --------------------------------------------------------------
	// Array mode register fields
	// --------------------------------------------------------------
	localparam int CCA_MD_IDLE  = 7;
	localparam int CCA_MD_WDT   = 6;
	localparam int CCA_MD_TB_HI = 3;
	localparam int CCA_MD_TB_LO = 1;
	localparam int CCA_MD_OVFIE = 0;

	// --------------------------------------------------------------
	// Array control register fields
	// --------------------------------------------------------------
	localparam int CCA_CN_OVF = 7;
	localparam int CCA_CN_RUN = 6;

	// --------------------------------------------------------------
	// Module mode register fields
	// --------------------------------------------------------------
	localparam int CCA_MM_W16  = 7;
	localparam int CCA_MM_ECOM = 6;
	localparam int CCA_MM_RISE = 5;
	localparam int CCA_MM_FALL = 4;
	localparam int CCA_MM_MAT  = 3;
	localparam int CCA_MM_TOG  = 2;
	localparam int CCA_MM_PWM  = 1;
	localparam int CCA_MM_IRQ  = 0;

	// --------------------------------------------------------------
	// Timebase selection and dividers
	// --------------------------------------------------------------
	localparam logic [2:0] CCA_TB_DIV12 = 3'h0;
	localparam logic [2:0] CCA_TB_DIV4  = 3'h1;
	localparam logic [2:0] CCA_TB_T0    = 3'h2;
	localparam logic [2:0] CCA_TB_EXT   = 3'h3;
	localparam logic [2:0] CCA_TB_SYS   = 3'h4;
	localparam logic [2:0] CCA_TB_OSC8  = 3'h5;
	localparam logic [3:0] CCA_DIV12_LAST = 4'hB;
	localparam logic [3:0] CCA_DIV4_LAST  = 4'h3;
	localparam logic [3:0] CCA_OSC8_LAST  = 4'h7;

	// --------------------------------------------------------------
	// Count values
	// --------------------------------------------------------------
	localparam logic [15:0] CCA_CNT_MAX  = 16'hFFFF;
	localparam logic [15:0] CCA_CNT_ZERO = 16'h0000;
	localparam logic [7:0]  CCA_BYTE_ZERO = 8'h00;

endpackage

/* rtl/cca_timebase.sv */
// Purpose: Selects and generates the counter increment tick
// Assumes: All inputs synchronous to clk_sys
// Notes:   Prescalers free-run; tick is gated by run
`timescale 1ns/1ns
module cca_timebase (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// Control
	input  wire logic [2:0] timebaseSelect,
	input  wire logic       run,
	// Sources
	input  wire logic       timer0Ovf,
	input  wire logic       externalCountInput,
	input  wire logic       extOscIn,
	// Tick out
	output logic            tick
);
	import cca_pkg::*;

	typedef struct packed {
		logic [3:0] div12;
		logic [3:0] div4;
		logic [3:0] osc8;
		logic       extPrev;
		logic       oscPrev;
		logic       tick;
	} cca_tb_state_t;

	cca_tb_state_t s_reg;
	cca_tb_state_t s_next;

	always_comb
	begin
		s_next = s_reg;
		s_next.extPrev = externalCountInput;
		s_next.oscPrev = extOscIn;
		s_next.div12 = (s_reg.div12 == CCA_DIV12_LAST) ? '0 :
			s_reg.div12 + 4'h1;
		s_next.div4 = (s_reg.div4 == CCA_DIV4_LAST) ? '0 :
			s_reg.div4 + 4'h1;
		if (extOscIn && !s_reg.oscPrev)
		begin
			s_next.osc8 = (s_reg.osc8 == CCA_OSC8_LAST) ? '0 :
				s_reg.osc8 + 4'h1;
		end
		case (timebaseSelect)
			CCA_TB_DIV12: s_next.tick = run && s_reg.div12 == CCA_DIV12_LAST;
			CCA_TB_DIV4:  s_next.tick = run && s_reg.div4 == CCA_DIV4_LAST;
			CCA_TB_T0:    s_next.tick = run && timer0Ovf;
			CCA_TB_EXT:   s_next.tick = run && s_reg.extPrev &&
				!externalCountInput;
			CCA_TB_SYS:   s_next.tick = run;
			CCA_TB_OSC8:  s_next.tick = run && extOscIn && !s_reg.oscPrev &&
				s_reg.osc8 == CCA_OSC8_LAST;
			default:      s_next.tick = 1'h0;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign tick = s_reg.tick;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	sys_tick_a: assert property (@(posedge clk_sys) disable iff (rst)
		(timebaseSelect == CCA_TB_SYS && run) |=> tick)
		else $error("system clock timebase did not tick");

	div12_gap_a: assert property (@(posedge clk_sys) disable iff (rst)
		(tick && timebaseSelect == CCA_TB_DIV12 && run) |=> !tick)
		else $error("divide by 12 timebase ticked twice in a row");

endmodule // cca_timebase

/* rtl/cca_edge.sv */
// Purpose: Edge detection on the five module input lines
// Assumes: Inputs synchronous to clk_sys
// Notes:   Pulses are one cycle long, one cycle after the edge
`timescale 1ns/1ns
module cca_edge (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// Lines
	input  wire logic [4:0] lineIn,
	// Edge pulses
	output logic      [4:0] rise,
	output logic      [4:0] fall
);
	import cca_pkg::*;

	typedef struct packed {
		logic [4:0] prev;
		logic [4:0] rise;
		logic [4:0] fall;
	} cca_edge_state_t;

	cca_edge_state_t s_reg;
	cca_edge_state_t s_next;

	always_comb
	begin
		s_next = s_reg;
		s_next.prev = lineIn;
		s_next.rise = lineIn & ~s_reg.prev;
		s_next.fall = ~lineIn & s_reg.prev;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign rise = s_reg.rise;
	assign fall = s_reg.fall;

endmodule // cca_edge

/* rtl/cca_counter_array.sv */
// Purpose: Counter array with five capture/compare modules
// Assumes: Single clock; byte register port with read/write strobes
// Notes:   Watchdog restrictions only; watchdog reset lives elsewhere
`timescale 1ns/1ns

module cca_counter_array (
	// Clock and reset
	input  wire logic                       clk_sys,
	input  wire logic                       rst,
	// Register port
	input  wire logic                       regWrite,
	input  wire logic                       regRead,
	input  wire logic [cca_pkg::CCA_AW-1:0] regAddr,
	input  wire logic [7:0]                 regWrData,
	output logic      [7:0]                 regRdData,
	// System inputs
	input  wire logic                       cpuIdle,
	input  wire logic                       timer0Ovf,
	input  wire logic                       externalCountInput,
	input  wire logic                       extOscIn,
	// Module lines
	input  wire logic [4:0]                 moduleIoLineIn,
	output logic      [4:0]                 moduleIoLineOut,
	output logic      [4:0]                 moduleIoLineOeN,
	// Status
	output logic                            irqReq,
	output logic                            watchdogEnabled
);
	import cca_pkg::*;

	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	typedef struct packed {
		logic [15:0]                count;
		logic [7:0]                 snapshot;
		logic                       idleSuspend;
		logic                       watchdogEnable;
		logic [2:0]                 timebaseSelect;
		logic                       overflowIrqEnable;
		logic                       runEnable;
		logic                       counterOverflowFlag;
		logic [CCA_MODS-1:0]        moduleMatchFlag;
		logic [CCA_MODS-1:0][7:0]   moduleModeReg;
		logic [CCA_MODS-1:0][7:0]   valueLow;
		logic [CCA_MODS-1:0][7:0]   valueHigh;
		logic [CCA_MODS-1:0]        ioOut;
		logic [CCA_MODS-1:0]        ioOeN;
		logic                       step;
		logic [7:0]                 rdData;
		logic                       irq;
	} cca_state_t;

	cca_state_t s_reg;
	cca_state_t s_next;

	logic       counting;
	logic       tick;
	logic [4:0] capRise;
	logic [4:0] capFall;

	function automatic logic modHit(input logic [5:0] a,
		input logic [5:0] base, input int n);
		return a == base + 6'(n);
	endfunction

	// --------------------------------------------------------------
	// Timebase and edge detection
	// --------------------------------------------------------------
	// idle gating
	assign counting = (s_reg.runEnable | s_reg.watchdogEnable) &
		~(s_reg.idleSuspend & cpuIdle);

	cca_timebase u_timebase (
		.clk_sys            (clk_sys),
		.rst                (rst),
		.timebaseSelect     (s_reg.timebaseSelect),
		.run                (counting),
		.timer0Ovf          (timer0Ovf),
		.externalCountInput (externalCountInput),
		.extOscIn           (extOscIn),
		.tick               (tick)
	);

	cca_edge u_edge (
		.clk_sys (clk_sys),
		.rst     (rst),
		.lineIn  (moduleIoLineIn),
		.rise    (capRise),
		.fall    (capFall)
	);

	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	always_comb
	begin
		logic [7:0]  m;
		logic        full;
		logic        lowMatch;
		logic        modWrOk;
		logic [4:0]  irqEn;
		m = '0;
		full = 1'h0;
		lowMatch = 1'h0;
		modWrOk = 1'h0;
		irqEn = '0;
		s_next = s_reg;
		s_next.step = tick;

		// Counter and overflow
		if (tick)
		begin
			s_next.count = s_reg.count + 16'h0001;
		end

		// Register reads
		if (regRead)
		begin
			if (regAddr == CCA_A_CNT_LO)
			begin
				s_next.rdData = s_reg.count[7:0];
				s_next.snapshot = s_reg.count[15:8];
			end
			else if (regAddr == CCA_A_CNT_HI)
				s_next.rdData = s_reg.snapshot;
			else if (regAddr == CCA_A_MODE)
				s_next.rdData = {s_reg.idleSuspend, s_reg.watchdogEnable,
					2'h0, s_reg.timebaseSelect, s_reg.overflowIrqEnable};
			else if (regAddr == CCA_A_CTRL)
				s_next.rdData = {s_reg.counterOverflowFlag, s_reg.runEnable,
					1'h0, s_reg.moduleMatchFlag};
			else
			begin
				s_next.rdData = CCA_BYTE_ZERO;
				for (int i = 0; i < CCA_MODS; i++)
				begin
					if (modHit(regAddr, CCA_A_MMODE0, i))
						s_next.rdData = s_reg.moduleModeReg[i];
					else if (modHit(regAddr, CCA_A_VLO0, i))
						s_next.rdData = s_reg.valueLow[i];
					else if (modHit(regAddr, CCA_A_VHI0, i))
						s_next.rdData = s_reg.valueHigh[i];
				end
			end
		end

		// Register writes
		if (regWrite)
		begin
			if (regAddr == CCA_A_CNT_LO && !s_reg.watchdogEnable)
				s_next.count[7:0] = regWrData;
			else if (regAddr == CCA_A_CNT_HI && !s_reg.watchdogEnable)
				s_next.count[15:8] = regWrData;
			else if (regAddr == CCA_A_MODE)
			begin
				s_next.watchdogEnable = regWrData[CCA_MD_WDT];
				if (!s_reg.watchdogEnable)
				begin
					s_next.idleSuspend = regWrData[CCA_MD_IDLE];
					s_next.timebaseSelect =
						regWrData[CCA_MD_TB_HI:CCA_MD_TB_LO];
					s_next.overflowIrqEnable = regWrData[CCA_MD_OVFIE];
				end
			end
			else if (regAddr == CCA_A_CTRL)
			begin
				s_next.counterOverflowFlag = regWrData[CCA_CN_OVF];
				s_next.runEnable = regWrData[CCA_CN_RUN];
				s_next.moduleMatchFlag = regWrData[CCA_MODS-1:0];
			end
		end

		// overflow sets flag, wins over a clear
		if (tick && s_reg.count == CCA_CNT_MAX)
			s_next.counterOverflowFlag = 1'h1;

		for (int i = 0; i < CCA_MODS; i++)
		begin
			modWrOk = !(i == CCA_WDT_MOD && s_reg.watchdogEnable);
			if (regWrite && modWrOk)
			begin
				if (modHit(regAddr, CCA_A_MMODE0, i))
					s_next.moduleModeReg[i] = regWrData;
				else if (modHit(regAddr, CCA_A_VLO0, i))
				begin
					s_next.valueLow[i] = regWrData;
					s_next.moduleModeReg[i][CCA_MM_ECOM] = 1'h0;
				end
				else if (modHit(regAddr, CCA_A_VHI0, i))
				begin
					s_next.valueHigh[i] = regWrData;
					s_next.moduleModeReg[i][CCA_MM_ECOM] = 1'h1;
				end
			end

			m = s_reg.moduleModeReg[i];
			full = s_reg.count == {s_reg.valueHigh[i], s_reg.valueLow[i]};
			lowMatch = s_reg.count[7:0] == s_reg.valueLow[i];

			if (!m[CCA_MM_MAT] && !m[CCA_MM_TOG] && !m[CCA_MM_PWM] &&
				((m[CCA_MM_RISE] && capRise[i]) ||
				(m[CCA_MM_FALL] && capFall[i])))
			begin
				s_next.valueLow[i] = s_reg.count[7:0];
				s_next.valueHigh[i] = s_reg.count[15:8];
				s_next.moduleMatchFlag[i] = 1'h1;
			end

			if (m[CCA_MM_ECOM] && s_reg.step)
			begin
				if (m[CCA_MM_PWM] && m[CCA_MM_TOG])
				begin
					// zero step wraps after 256 ticks
					if (lowMatch)
					begin
						s_next.ioOut[i] = !s_reg.ioOut[i];
						s_next.valueLow[i] = s_reg.valueLow[i] +
							s_reg.valueHigh[i];
					end
				end
				else if (m[CCA_MM_PWM] && m[CCA_MM_W16])
				begin
					if (full)
						s_next.ioOut[i] = 1'h1;
					else if (s_reg.count == CCA_CNT_ZERO)
						s_next.ioOut[i] = 1'h0;
					if (full && m[CCA_MM_MAT])
						s_next.moduleMatchFlag[i] = 1'h1;
				end
				else if (m[CCA_MM_PWM])
				begin
					if (s_reg.count[7:0] == CCA_BYTE_ZERO)
					begin
						s_next.valueLow[i] = s_reg.valueHigh[i];
						s_next.ioOut[i] =
							s_reg.valueHigh[i] == CCA_BYTE_ZERO;
					end
					else if (lowMatch)
						s_next.ioOut[i] = 1'h1;
				end
				else if (m[CCA_MM_MAT] && full)
				begin
					s_next.moduleMatchFlag[i] = 1'h1;
					if (m[CCA_MM_TOG])
						s_next.ioOut[i] = !s_reg.ioOut[i];
				end
			end

			if (m[CCA_MM_PWM] && !m[CCA_MM_ECOM])
				s_next.ioOut[i] = 1'h0;

			s_next.ioOeN[i] = !(s_next.moduleModeReg[i][CCA_MM_TOG] ||
				s_next.moduleModeReg[i][CCA_MM_PWM]);
			irqEn[i] = s_next.moduleModeReg[i][CCA_MM_IRQ];
		end

		s_next.irq = (s_next.counterOverflowFlag &
			s_next.overflowIrqEnable) |
			(|(s_next.moduleMatchFlag & irqEn));
	end

	// --------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			s_reg <= '0;
			s_reg.watchdogEnable <= 1'h1;
			s_reg.ioOeN <= '1;
		end
		else
			s_reg <= s_next;
	end

	assign regRdData = s_reg.rdData;
	assign moduleIoLineOut = s_reg.ioOut;
	assign moduleIoLineOeN = s_reg.ioOeN;
	assign irqReq = s_reg.irq;
	assign watchdogEnabled = s_reg.watchdogEnable;

	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	ovf_flag_set_a: assert property (
		(tick && s_reg.count == CCA_CNT_MAX) |=>
		(s_reg.counterOverflowFlag && s_reg.count == CCA_CNT_ZERO))
		else $error("overflow did not set flag");

	ovf_flag_hold_a: assert property (
		(s_reg.counterOverflowFlag &&
		!(regWrite && regAddr == CCA_A_CTRL)) |=>
		s_reg.counterOverflowFlag)
		else $error("overflow flag cleared without a write");

	snap_take_a: assert property (
		(regRead && regAddr == CCA_A_CNT_LO) |=>
		(s_reg.snapshot == $past(s_reg.count[15:8]) &&
		regRdData == $past(s_reg.count[7:0])))
		else $error("low byte read did not snapshot high byte");

	snap_return_a: assert property (
		(regRead && regAddr == CCA_A_CNT_HI) |=>
		regRdData == $past(s_reg.snapshot))
		else $error("high byte read did not return snapshot");

	lo_clears_ecom_a: assert property (
		(regWrite && regAddr == CCA_A_VLO0) |=>
		!s_reg.moduleModeReg[0][CCA_MM_ECOM])
		else $error("low value write left compare enabled");

	hi_sets_ecom_a: assert property (
		(regWrite && regAddr == CCA_A_VHI0) |=>
		s_reg.moduleModeReg[0][CCA_MM_ECOM])
		else $error("high value write did not enable compare");

	pwm_zero_duty_a: assert property (
		(s_reg.moduleModeReg[0][CCA_MM_PWM] &&
		!s_reg.moduleModeReg[0][CCA_MM_ECOM]) |=> !moduleIoLineOut[0])
		else $error("disabled pulse width output not low");

	mod_flag_hold_a: assert property (
		(s_reg.moduleMatchFlag[0] &&
		!(regWrite && regAddr == CCA_A_CTRL)) |=>
		s_reg.moduleMatchFlag[0])
		else $error("module flag cleared by hardware");

	wdt_freeze_a: assert property (
		(s_reg.watchdogEnable && regWrite && regAddr == CCA_A_MODE) |=>
		s_reg.timebaseSelect == $past(s_reg.timebaseSelect))
		else $error("timebase changed while watchdog enabled");

	capture_copy_a: assert property (
		(capRise[0] && s_reg.moduleModeReg[0][CCA_MM_RISE] &&
		s_reg.moduleModeReg[0][CCA_MM_PWM:CCA_MM_TOG] == 2'h0 &&
		!s_reg.moduleModeReg[0][CCA_MM_MAT]) |=>
		({s_reg.valueHigh[0], s_reg.valueLow[0]} == $past(s_reg.count) &&
		s_reg.moduleMatchFlag[0]))
		else $error("capture did not copy count and flag");

	idle_run_a: assert property (
		(!s_reg.idleSuspend && cpuIdle && s_reg.runEnable) |-> counting)
		else $error("counter suspended in idle with suspend clear");

	overflow_c: cover property (tick && s_reg.count == CCA_CNT_MAX);
	capture_c: cover property (capRise[0] && s_reg.moduleModeReg[0] ==
		8'h20);
	pwm_high_c: cover property (s_reg.moduleModeReg[1][CCA_MM_PWM] &&
		$rose(moduleIoLineOut[1]));
	wdt_off_c: cover property ($fell(s_reg.watchdogEnable));

endmodule // cca_counter_array

/* verif/cca_pin_model.sv */
// Purpose: Far-side pins of the counter array module lines
// Assumes: Bench sets the level of every released line
// Notes:   Count and oscillator inputs free-run from a small divider
`timescale 1ns/1ns
module cca_pin_model (
	// Clock
	input  wire logic       clk_sys,
	// Design side
	input  wire logic [4:0] lineOut,
	input  wire logic [4:0] lineOeN,
	output logic      [4:0] lineIn,
	output logic            extCount,
	output logic            extOsc,
	// Scenario control
	input  wire logic [4:0] drive
);
	logic [2:0] div_reg = 3'h0;

	// Pin level from whichever party drives it
	assign lineIn = (lineOeN & drive) | (~lineOeN & lineOut);

	// count input at an eighth of the clock rate
	assign extCount = div_reg[2];
	assign extOsc   = div_reg[0];

	always_ff @(posedge clk_sys)
		div_reg <= div_reg + 3'h1;
endmodule // cca_pin_model

/* verif/cca_counter_array_tb_top.sv */
// Purpose: Self-checking bench for the counter array
// Assumes: Watchdog cleared first; counter stopped while loading
// Notes:   Registers reached through the strobe port tasks
`timescale 1ns/1ns
module cca_counter_array_tb_top;
	import cca_pkg::*;
	logic        clk_sys;
	logic        rst;
	logic        regWrite;
	logic        regRead;
	logic [5:0]  regAddr;
	logic [7:0]  regWrData;
	logic [7:0]  regRdData;
	logic        cpuIdle;
	logic        t0Ovf;
	logic [4:0]  lineIn;
	logic [4:0]  lineOut;
	logic [4:0]  lineOeN;
	logic [4:0]  drive;
	logic        extCount;
	logic        extOsc;
	logic        irqReq;
	logic        wdEn;
	logic [7:0]  rdv;
	logic [15:0] cv;
	logic [7:0]  capMode [3] = '{8'h21, 8'h11, 8'h31};
	int          fail_count = 0;
	int          samples_checked = 0;
	int          highs;
	int          flips;

	cca_counter_array dut_u (
		.clk_sys(clk_sys), .rst(rst), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWrData(regWrData),
		.regRdData(regRdData), .cpuIdle(cpuIdle), .timer0Ovf(t0Ovf),
		.externalCountInput(extCount), .extOscIn(extOsc),
		.moduleIoLineIn(lineIn), .moduleIoLineOut(lineOut),
		.moduleIoLineOeN(lineOeN), .irqReq(irqReq),
		.watchdogEnabled(wdEn));

	cca_pin_model pins_u (
		.clk_sys(clk_sys), .lineOut(lineOut), .lineOeN(lineOeN),
		.lineIn(lineIn), .extCount(extCount), .extOsc(extOsc),
		.drive(drive));

	// ------------------------------------------------------------
	// Access and check tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#1;
		regWrite = 1'b1;
		regAddr = a;
		regWrData = d;
		@(posedge clk_sys);
		#1;
		regWrite = 1'b0;
	endtask

	task automatic rd(input logic [5:0] a);
		@(posedge clk_sys);
		#1;
		regRead = 1'b1;
		regAddr = a;
		@(posedge clk_sys);
		#1;
		regRead = 1'b0;
		rdv = regRdData;
	endtask

	task automatic wrCnt(input logic [15:0] v);
		wr(CCA_A_CNT_LO, v[7:0]);
		wr(CCA_A_CNT_HI, v[15:8]);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// Highs on line 2 and changes on line 3
	task automatic measure(input int n);
		logic p;
		highs = 0;
		flips = 0;
		p = lineOut[3];
		repeat (n)
		begin
			@(posedge clk_sys);
			#1;
			highs += int'(lineOut[2] === 1'b1);
			flips += int'(lineOut[3] !== p);
			p = lineOut[3];
		end
	endtask

	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	initial
	begin
		repeat (20000) @(posedge clk_sys);
		fail_count++;
		stop_test();
	end

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 6'h00;
		regWrData = 8'h00;
		cpuIdle = 1'b0;
		t0Ovf = 1'b0;
		drive = 5'h00;
		cyc(6);
		rst = 1'b0;
		chk(wdEn, 1'b1); // watchdog on
		chk(lineOeN, 5'h1F);
		rd(CCA_A_MODE);
		chk(rdv, 8'h40); // mode default
		wr(CCA_A_MODE, 8'h08);
		rd(CCA_A_MODE);
		chk(rdv, 8'h00); // select frozen
		wr(CCA_A_MODE, 8'h09);
		wrCnt(16'hFFFE);
		rd(CCA_A_CNT_LO);
		chk(rdv, 8'hFE); // low byte
		rd(CCA_A_CNT_HI);
		chk(rdv, 8'hFF); // high byte
		wr(CCA_A_CTRL, 8'h40);
		cyc(8);
		chk(irqReq, 1'b1); // wrap request
		rd(CCA_A_CTRL);
		chk(rdv, 8'hC0); // flag kept
		wr(CCA_A_CTRL, 8'h40);
		cyc(2);
		chk(irqReq, 1'b0); // cleared by write
		wr(CCA_A_CTRL, 8'h00);
		$display("Test counter done");
		for (int i = 0; i < 3; i++)
		begin
			wr(CCA_A_CTRL, 8'h00);
			wr(CCA_A_MMODE0, capMode[i]);
			wrCnt({8'hA0, 6'h00, i[1:0]});
			drive[0] = 1'b1; // level held
			cyc(4);
			wrCnt({8'hB0, 6'h00, i[1:0]});
			drive[0] = 1'b0; // level held
			cyc(4);
			cv = {(i == 0) ? 8'hA0 : 8'hB0, 6'h00, i[1:0]};
			rd(CCA_A_VLO0);
			chk(rdv, cv[7:0]); // low byte, same for both edges
			rd(CCA_A_VHI0);
			chk(rdv, cv[15:8]); // high byte of capture
			rd(CCA_A_CTRL);
			chk(rdv, 8'h01); // flag set
			chk(irqReq, 1'b1); // enabled request
		end
		$display("Test capture done");
		wr(CCA_A_MMODE0 + 6'h1, 8'h4C);
		wr(CCA_A_VLO0 + 6'h1, 8'h00);
		rd(CCA_A_MMODE0 + 6'h1);
		chk(rdv, 8'h0C); // low write clears
		wr(CCA_A_VHI0 + 6'h1, 8'h01);
		rd(CCA_A_MMODE0 + 6'h1);
		chk(rdv, 8'h4C); // high write sets
		wr(CCA_A_MMODE0 + 6'h2, 8'h42);
		wr(CCA_A_VLO0 + 6'h2, 8'h80);
		wr(CCA_A_VHI0 + 6'h2, 8'h80);
		wr(CCA_A_MMODE0 + 6'h3, 8'h46);
		wr(CCA_A_VLO0 + 6'h3, 8'h00);
		wr(CCA_A_VHI0 + 6'h3, 8'h10);
		wrCnt(16'h00F0);
		wr(CCA_A_CTRL, 8'h40);
		cyc(24);
		chk(lineOut[1], 1'b1); // toggled on match
		chk(lineOeN[1], 1'b0);
		rd(CCA_A_CTRL);
		chk(rdv & 8'hC2, 8'h42); // match flag
		cpuIdle = 1'b1;
		measure(512); // runs while idle
		cpuIdle = 1'b0;
		chk(highs, 256); // half duty
		chk(flips, 32); // step of sixteen
		wr(CCA_A_MMODE0 + 6'h2, 8'h02);
		wr(CCA_A_VHI0 + 6'h3, 8'h00);
		cyc(3);
		measure(512);
		chk(highs, 0); // output held low
		chk(flips, 2); // zero means 256
		$display("Test compare and waveform done");
		wr(CCA_A_CTRL, 8'h00);
		wr(CCA_A_MODE, 8'h05);
		wrCnt(16'h0000);
		wr(CCA_A_CTRL, 8'h40);
		repeat (5)
		begin
			t0Ovf = 1'b1;
			cyc(1);
			t0Ovf = 1'b0;
			cyc(1);
		end
		wr(CCA_A_CTRL, 8'h00);
		rd(CCA_A_CNT_LO);
		chk(rdv, 8'h05); // timer 0 overflow source
		wr(CCA_A_MODE, 8'h09);
		$display("Test timebase done");
		wr(CCA_A_MMODE0 + 6'h1, 8'hCB);
		wr(CCA_A_VLO0 + 6'h1, 8'h00); // low byte first
		wr(CCA_A_VHI0 + 6'h1, 8'hFF); // then high byte
		chk(lineOut[1], 1'b0); // low while stopped
		wrCnt(16'hFEF0);
		wr(CCA_A_CTRL, 8'h40);
		cyc(24);
		chk(lineOut[1], 1'b1); // high on match
		chk(irqReq, 1'b1); // match interrupt for updates
		cyc(256);
		chk(lineOut[1], 1'b0); // low on overflow
		$display("Test wide pulse width done");
		stop_test();
	end
endmodule // cca_counter_array_tb_top
